// file: tfp_pkg.sv
// Shared constants, level codes, modes and carriers of the fan sequencer.
// Assumes the control inputs arrive as 8-bit codes, full scale equals VDD.

package tfp_pkg;

    // Level codes: 8-bit fraction of the supply
    localparam int LVL_W           = 8;
    localparam int CODE_FULL_SCALE = 255;
    localparam int VDD_MV          = 5000;

    // Percent of supply to level code, truncated
    function automatic logic [7:0] tfp_pct_code(input int pct);
        return 8'(pct * CODE_FULL_SCALE / 100);
    endfunction

    // Millivolts to level code at the nominal supply
    function automatic logic [7:0] tfp_mv_code(input int mv);
        return 8'(mv * CODE_FULL_SCALE / VDD_MV);
    endfunction

    // Nominal thresholds in percent of supply and millivolts
    localparam int PWM_MIN_PCT     = 30;
    localparam int FULL_DUTY_PCT   = 70;
    localparam int OVERHEAT_PCT    = 77;
    localparam int HYST_PCT        = 11;
    localparam int SHUTDOWN_MV     = 700;
    localparam int RESTART_MV      = 1100;

    localparam logic [7:0] PWM_MIN_CODE   = tfp_pct_code(PWM_MIN_PCT);
    localparam logic [7:0] FULL_DUTY_CODE = tfp_pct_code(FULL_DUTY_PCT);
    localparam logic [7:0] OVERHEAT_CODE  = tfp_pct_code(OVERHEAT_PCT);
    localparam logic [7:0] HYST_CODE      = tfp_pct_code(HYST_PCT);
    localparam logic [7:0] SHUTDOWN_CODE  = tfp_mv_code(SHUTDOWN_MV);
    localparam logic [7:0] RESTART_CODE   = tfp_mv_code(RESTART_MV);
    // A sleep threshold at or below this code counts as grounded
    localparam logic [7:0] SLEEP_GND_CODE = 8'h05;
    localparam logic [7:0] DUTY_TOP       = 8'hff;
    localparam logic [7:0] DUTY_ZERO      = 8'h00;

    // Timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int TB_FREQ_HZ      = 30;
    localparam int TB_PERIOD_CYC   = CLK_HZ / TB_FREQ_HZ;
    localparam int RAMP_STEPS      = 256;
    localparam int STARTUP_PERIODS = 64;
    localparam int CNT_W           = 6;
    localparam int RESET_HOLD_US   = 30;
    localparam int RESET_HOLD_CYC  = (RESET_HOLD_US * (CLK_HZ / 1_000_000));

    // Sequencer modes
    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_START = 2'b10,
        ST_RUN   = 2'b11
    } tfp_mode_type;

    // Sampled control levels
    typedef struct packed {
        logic [7:0] primary;
        logic [7:0] secondary;
        logic [7:0] sleep_thr;
    } tfp_levels_type;

    // Quantized duty request
    typedef struct packed {
        logic       full;
        logic       sec_sel;
        logic [7:0] level;
    } tfp_duty_type;

endpackage

// file: tfp_timebase.sv
// Time base: prescaler and per-period ramp count for the PWM.
// Assumes a synchronous restart from the sequencer, one clock domain.
`timescale 1ns/10ps
`default_nettype none

module tfp_timebase #(
    parameter int STEP_CYC = tfp_pkg::TB_PERIOD_CYC / tfp_pkg::RAMP_STEPS
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       restart,
    // Time base
    output logic      [7:0] ramp,
    output logic            period_end
);

    localparam int PRE_W = $clog2(STEP_CYC + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYC - 1);

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [7:0]       ramp;
        logic             period_end;
    } tfp_tb_state_type;

    tfp_tb_state_type st_r;
    tfp_tb_state_type st_nxt;

    // Ramp steps once per prescaler wrap; period ends at ramp wrap
    always_comb begin
        st_nxt            = st_r;
        st_nxt.period_end = 1'b0;
        if (restart) begin
            st_nxt.pre  = '0;
            st_nxt.ramp = tfp_pkg::DUTY_ZERO;
        end else if (st_r.pre == PRE_LAST) begin
            st_nxt.pre  = '0;
            st_nxt.ramp = st_r.ramp + 8'h01;
            if (st_r.ramp == tfp_pkg::DUTY_TOP) begin
                st_nxt.period_end = 1'b1; // R11
            end
        end else begin
            st_nxt.pre = st_r.pre + PRE_W'(1);
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ramp       = st_r.ramp;
    assign period_end = st_r.period_end;

endmodule

`default_nettype wire

// file: tfp_duty_map.sv
// Duty request: picks the higher control input and quantizes it.
// Assumes level codes on the package scale, refreshed every clock.
`timescale 1ns/10ps
`default_nettype none

module tfp_duty_map #(
    parameter logic [7:0] MIN_CODE  = tfp_pkg::PWM_MIN_CODE,
    parameter logic [7:0] FULL_CODE = tfp_pkg::FULL_DUTY_CODE
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // Levels in, duty out
    input  wire tfp_pkg::tfp_levels_type levels,
    output tfp_pkg::tfp_duty_type        duty
);

    tfp_pkg::tfp_duty_type st_r;
    tfp_pkg::tfp_duty_type st_nxt;

    // Linear map of the span onto the ramp range, clamped both ends
    function automatic logic [7:0] span_map(input logic [7:0] v);
        int num;
        num = 0;
        if (v <= MIN_CODE) begin
            return tfp_pkg::DUTY_ZERO;
        end else if (v >= FULL_CODE) begin
            return tfp_pkg::DUTY_TOP;
        end
        num = (int'(v) - int'(MIN_CODE)) * tfp_pkg::CODE_FULL_SCALE;
        return 8'(num / (int'(FULL_CODE) - int'(MIN_CODE)));
    endfunction

    // Higher input controls; a tie stays with the primary
    always_comb begin
        logic [7:0] hi;
        hi             = levels.primary;
        st_nxt.sec_sel = levels.secondary > levels.primary; // R1
        if (st_nxt.sec_sel) begin
            hi = levels.secondary;
        end
        st_nxt.full  = hi >= FULL_CODE; // R2
        st_nxt.level = span_map(hi); // R16
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign duty = st_r;

endmodule

`default_nettype wire

// file: tfp_fan_seq.sv
// Fan sequencer top: shutdown, sleep, startup interval, PWM and fault.
// Assumes control levels are synchronous 8-bit codes of the supply;
// the fault pin is open drain, resolved outside from its enable.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1: Duty follows the higher control input outside the startup interval.
// R2: Drive stays high whenever the controlling level exceeds full duty.
// R3: Primary above overheat threshold pulls fault low; fan keeps full duty.
// R4: Primary back below overheat releases fault; duty follows inputs again.
// R5: Both inputs below sleep threshold, primary above shutdown: sleep.
// R6: Only one input below sleep threshold keeps normal operation.
// R7: Either input above wake level leaves sleep and runs 64 forced periods.
// R8: On each start from sleep the drive is forced on for 64 time-base periods.
// R9: Primary below shutdown level stops everything, secondary regardless.
// R10: Outside party holds primary below shutdown 30 us for a sure reset.
// R11: One time-base period clocks the sequencing and is the PWM period.
// R12: Primary above restart level after shutdown acts as a full power-up.
// R13: In sleep the fault flag is inactive and the drive is off.
// R14: After reset the fan waits until an input rises above wake level.
// R15: A grounded sleep threshold disables sleep entirely.
// R16: PWM compares a ramp against the quantized higher input level.
// R17: Startup counter loads on each start and hands over after 64 periods.
module tfp_fan_seq #(
    parameter int         TB_PERIOD_CYC = tfp_pkg::TB_PERIOD_CYC,
    parameter logic [7:0] SHUTDOWN_CODE = tfp_pkg::SHUTDOWN_CODE,
    parameter logic [7:0] RESTART_CODE  = tfp_pkg::RESTART_CODE,
    parameter logic [7:0] OVERHEAT_CODE = tfp_pkg::OVERHEAT_CODE,
    parameter logic [7:0] HYST_CODE     = tfp_pkg::HYST_CODE
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rstn,
    // Sampled control levels
    input  wire tfp_pkg::tfp_levels_type levels,
    // Fan drive pin
    output logic                         fan_drive,
    output logic                         fan_drive_oe,
    // Open-drain overheat fault pin
    output logic                         overheat_fault_n,
    output logic                         overheat_fault_oe,
    // Status
    output tfp_pkg::tfp_mode_type        mode,
    output logic                         secondary_in_control
);

    localparam int STEP_CYC = (TB_PERIOD_CYC / tfp_pkg::RAMP_STEPS) < 1 ?
                              1 : TB_PERIOD_CYC / tfp_pkg::RAMP_STEPS;
    localparam logic [tfp_pkg::CNT_W-1:0] START_LAST =
        tfp_pkg::CNT_W'(tfp_pkg::STARTUP_PERIODS - 1);

    typedef struct packed {
        tfp_pkg::tfp_mode_type       mode;
        logic [tfp_pkg::CNT_W-1:0]   cnt;
        logic                        drive;
        logic                        drive_oe;
        logic                        fault_n;
        logic                        fault_oe;
        logic                        sec_sel;
    } tfp_seq_state_type;

    logic [1:0]            rst_sync_r;
    logic                  rst_n;
    tfp_seq_state_type     st_r;
    tfp_seq_state_type     st_nxt;
    tfp_pkg::tfp_duty_type duty;
    logic [7:0]            ramp;
    logic                  period_end;
    logic                  tb_restart;
    logic                  below_shutdown;
    logic                  above_restart;
    logic                  sleep_enabled;
    logic                  sleep_cond;
    logic                  wake_cond;
    logic                  overheat;
    logic [8:0]            wake_level;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // Ramp and period ticks; restarted on each start so 64 are whole
    tfp_timebase #(
        .STEP_CYC   (STEP_CYC)
    ) tfp_timebase_i (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .restart    (tb_restart),
        .ramp       (ramp),
        .period_end (period_end)
    );

    // Quantized duty from the higher input
    tfp_duty_map tfp_duty_map_i (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .levels   (levels),
        .duty     (duty)
    );

    // Level comparisons; wake level carried in nine bits to avoid wrap
    assign wake_level     = {1'b0, levels.sleep_thr} + {1'b0, HYST_CODE};
    assign below_shutdown = levels.primary < SHUTDOWN_CODE; // R9
    assign above_restart  = levels.primary > RESTART_CODE; // R12
    assign sleep_enabled  = levels.sleep_thr > tfp_pkg::SLEEP_GND_CODE; // R15
    assign sleep_cond     = sleep_enabled &&
                            (levels.primary < levels.sleep_thr) &&
                            (levels.secondary < levels.sleep_thr); // R5 R6
    assign wake_cond      = !sleep_enabled ||
                            ({1'b0, levels.primary} > wake_level) ||
                            ({1'b0, levels.secondary} > wake_level); // R7 R14
    assign overheat       = levels.primary > OVERHEAT_CODE; // R3 R4

    // Mode sequencing; shutdown outranks every other condition
    always_comb begin
        st_nxt     = st_r;
        tb_restart = 1'b0;
        case (st_r.mode)
            tfp_pkg::ST_OFF: begin
                // Leaving shutdown behaves as power-up: wait for wake
                if (!below_shutdown && above_restart) begin
                    st_nxt.mode = tfp_pkg::ST_SLEEP; // R12 R14
                end
            end
            tfp_pkg::ST_SLEEP: begin
                if (below_shutdown) begin
                    st_nxt.mode = tfp_pkg::ST_OFF; // R9
                end else if (wake_cond) begin
                    st_nxt.mode = tfp_pkg::ST_START; // R7 R8
                    st_nxt.cnt  = '0; // R17
                    tb_restart  = 1'b1;
                end
            end
            tfp_pkg::ST_START: begin
                if (below_shutdown) begin
                    st_nxt.mode = tfp_pkg::ST_OFF; // R9
                end else if (sleep_cond) begin
                    st_nxt.mode = tfp_pkg::ST_SLEEP; // R5
                end else if (period_end) begin
                    st_nxt.cnt = st_r.cnt + tfp_pkg::CNT_W'(1); // R17
                    if (st_r.cnt == START_LAST) begin
                        st_nxt.mode = tfp_pkg::ST_RUN; // R8 R17
                    end
                end
            end
            tfp_pkg::ST_RUN: begin
                if (below_shutdown) begin
                    st_nxt.mode = tfp_pkg::ST_OFF; // R9
                end else if (sleep_cond) begin
                    st_nxt.mode = tfp_pkg::ST_SLEEP; // R5 R6
                end
            end
            default: begin
                st_nxt.mode = tfp_pkg::ST_OFF;
            end
        endcase

        // Pin values follow the mode being entered
        st_nxt.sec_sel = duty.sec_sel;
        case (st_nxt.mode)
            tfp_pkg::ST_START: begin
                st_nxt.drive    = 1'b1; // R7 R8
                st_nxt.drive_oe = 1'b1;
                st_nxt.fault_oe = overheat; // R3
            end
            tfp_pkg::ST_RUN: begin
                // Full level forces the drive on for the whole period
                st_nxt.drive    = duty.full ||
                                  (ramp < duty.level); // R1 R2 R16 R11
                st_nxt.drive_oe = 1'b1;
                st_nxt.fault_oe = overheat; // R3 R4
            end
            default: begin
                // Off and sleep: drive low and floated, fault released
                st_nxt.drive    = 1'b0; // R9 R13
                st_nxt.drive_oe = 1'b0;
                st_nxt.fault_oe = 1'b0; // R12 R13
            end
        endcase
        st_nxt.fault_n = !st_nxt.fault_oe;
    end

    // State register; comes out of reset as in shutdown
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.mode     <= tfp_pkg::ST_OFF;
            st_r.cnt      <= '0;
            st_r.drive    <= 1'b0;
            st_r.drive_oe <= 1'b0;
            st_r.fault_n  <= 1'b1;
            st_r.fault_oe <= 1'b0;
            st_r.sec_sel  <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign fan_drive            = st_r.drive;
    assign fan_drive_oe         = st_r.drive_oe;
    assign overheat_fault_n     = st_r.fault_n;
    assign overheat_fault_oe    = st_r.fault_oe;
    assign mode                 = st_r.mode;
    assign secondary_in_control = st_r.sec_sel;

endmodule

`default_nettype wire

// file: tfp_fan_seq_props.sv
// Concurrent checks on the fan sequencer top, ports only.
// Assumes it is bound to tfp_fan_seq from the testbench top file.
`timescale 1ns/10ps
`default_nettype none
module tfp_fan_seq_props #(
    parameter int TB_PERIOD_CYC = 256
) (
    // Clock and reset
    input wire logic                    core_clk,
    input wire logic                    rstn,
    // Levels in
    input wire tfp_pkg::tfp_levels_type levels,
    // Pins and status
    input wire logic                    fan_drive,
    input wire logic                    fan_drive_oe,
    input wire logic                    overheat_fault_n,
    input wire logic                    overheat_fault_oe,
    input wire tfp_pkg::tfp_mode_type   mode,
    input wire logic                    secondary_in_control
);
    localparam int START_LEN = 64 * 256 * (TB_PERIOD_CYC / 256);
    logic        live;
    logic        on;
    logic [8:0]  wake_lvl;
    logic [31:0] start_cnt_r;
    // Derived conditions
    assign live     = levels.primary >= tfp_pkg::SHUTDOWN_CODE;
    assign on       = mode[1];
    assign wake_lvl = 9'(levels.sleep_thr) + 9'(tfp_pkg::HYST_CODE);
    // Cycles spent forced on, cleared outside the interval
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) start_cnt_r <= '0;
        else if (mode == tfp_pkg::ST_START) start_cnt_r <= start_cnt_r + 1;
        else start_cnt_r <= '0;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_hot;
        (levels.primary > tfp_pkg::FULL_DUTY_CODE
            && mode == tfp_pkg::ST_RUN)[*3];
    endsequence
    sequence s_start_done;
        mode == tfp_pkg::ST_START ##1 mode == tfp_pkg::ST_RUN;
    endsequence
    AST_FAULT_SET: assert property (on
        && levels.primary > tfp_pkg::OVERHEAT_CODE
        && levels.primary >= levels.sleep_thr
        |=> !overheat_fault_n && fan_drive)
        else $error("fault not raised while overheated");
    AST_FAULT_CLR: assert property (
        levels.primary <= tfp_pkg::OVERHEAT_CODE
        |=> overheat_fault_n && !overheat_fault_oe)
        else $error("fault held below overheat threshold");
    AST_SEC_SEL: assert property (secondary_in_control ==
        $past(levels.secondary > levels.primary, 2))
        else $error("controlling input flag wrong");
    AST_SHUTDOWN: assert property (!live |=> mode == tfp_pkg::ST_OFF
        && !fan_drive_oe && !fan_drive && overheat_fault_n)
        else $error("shutdown not taken");
    AST_QUIET: assert property (!on |-> !fan_drive_oe && !fan_drive
        && overheat_fault_n)
        else $error("pins active while asleep or off");
    AST_START_HIGH: assert property (mode == tfp_pkg::ST_START
        |-> fan_drive && fan_drive_oe)
        else $error("drive not forced during startup");
    AST_START_LEN: assert property (s_start_done
        |-> start_cnt_r inside {[START_LEN - 1 : START_LEN + 2]})
        else $error("startup interval length wrong");
    AST_FULL: assert property (s_hot |=> fan_drive)
        else $error("drive not full above full-duty level");
    AST_SLEEP_IN: assert property (on && live && levels.sleep_thr >
        tfp_pkg::SLEEP_GND_CODE && levels.primary < levels.sleep_thr
        && levels.secondary < levels.sleep_thr |=> mode == tfp_pkg::ST_SLEEP)
        else $error("sleep not entered");
    AST_ONE_LOW: assert property (on && live && (levels.primary >=
        levels.sleep_thr || levels.secondary >= levels.sleep_thr) |=> on)
        else $error("left operation with one input high");
    AST_GND: assert property (on && live && levels.sleep_thr <=
        tfp_pkg::SLEEP_GND_CODE |=> on)
        else $error("slept with grounded threshold");
    AST_WAKE: assert property (mode == tfp_pkg::ST_SLEEP && live
        && (9'(levels.primary) > wake_lvl || 9'(levels.secondary) > wake_lvl)
        |=> mode == tfp_pkg::ST_START)
        else $error("no wake above wake level");
endmodule
`default_nettype wire

// file: tfp_thermal_model.sv
// Divider and fan-control source model: slews levels toward targets.
// Assumes the testbench sets targets; a real divider never jumps.
`timescale 1ns/10ps
`default_nettype none
module tfp_thermal_model #(
    parameter int STEP = 8
) (
    // Clock
    input wire logic                core_clk,
    // Targets
    input wire logic [7:0]          primary_set,
    input wire logic [7:0]          secondary_set,
    input wire logic [7:0]          sleep_set,
    // Levels out
    output tfp_pkg::tfp_levels_type levels
);
    function automatic logic [7:0] slew(input logic [7:0] cur, tgt);
        int c;
        int t;
        c = int'(cur);
        t = int'(tgt);
        if (t > c + STEP) return 8'(c + STEP);
        if (c > t + STEP) return 8'(c - STEP);
        return tgt;
    endfunction
    initial levels = '0;
    // Finite slew; a long low hold gives the sure reset
    always @(posedge core_clk) begin
        levels.primary   <= slew(levels.primary, primary_set);
        levels.secondary <= slew(levels.secondary, secondary_set);
        levels.sleep_thr <= slew(levels.sleep_thr, sleep_set);
    end
endmodule
`default_nettype wire

// file: tfp_fan_seq_test.sv
// Self-checking bench for the fan sequencer with a divider model.
// Assumes a shortened time base of 256 cycles per period.
`timescale 1ns/10ps
`default_nettype none
module tfp_fan_seq_test;
    localparam int TBP = 256;
    localparam int START_CYC = 64 * TBP;
    logic                    core_clk = 1'b0;
    logic                    rstn = 1'b0;
    logic [7:0]              p_set = 8'h64;
    logic [7:0]              s_set = 8'h32;
    logic [7:0]              t_set = 8'h50;
    tfp_pkg::tfp_levels_type levels;
    logic                    fan_drive;
    logic                    fan_drive_oe;
    logic                    overheat_fault_n;
    logic                    overheat_fault_oe;
    logic                    secondary_in_control;
    tfp_pkg::tfp_mode_type   mode;
    int                      mismatches = 0;
    int                      checks = 0;
    int                      h;
    // 10 MHz clock
    always #50 core_clk = ~core_clk;
    tfp_thermal_model tfp_thermal_model_i (.core_clk(core_clk),
        .primary_set(p_set), .secondary_set(s_set), .sleep_set(t_set),
        .levels(levels));
    tfp_fan_seq #(.TB_PERIOD_CYC(TBP)) tfp_fan_seq_i (.core_clk(core_clk),
        .rstn(rstn), .levels(levels), .fan_drive(fan_drive),
        .fan_drive_oe(fan_drive_oe), .overheat_fault_n(overheat_fault_n),
        .overheat_fault_oe(overheat_fault_oe), .mode(mode),
        .secondary_in_control(secondary_in_control));
    // Step past the edge so registered outputs have landed
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
        end
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic rng(input string what, input int lo, input int hi,
                       input int got);
        checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic lv(input logic [7:0] p, s, t);
        @(posedge core_clk);
        p_set <= p;
        s_set <= s;
        t_set <= t;
        cyc(300);
    endtask
    task automatic wait_mode(input tfp_pkg::tfp_mode_type m, input int n);
        for (int i = 0; i < n && mode !== m; i++) cyc(1);
        chk("mode", 32'(m), 32'(mode));
    endtask
    // High cycles over exactly one ramp period; unknown drive spoils it
    task automatic duty();
        h = 0;
        repeat (TBP) begin
            cyc(1);
            h += (fan_drive === 1'b1) ? 1 : ((fan_drive === 1'b0) ? 0 : 1000);
        end
    endtask
    task automatic t_powerup();
        cyc(300);
        chk("mode", 32'(tfp_pkg::ST_SLEEP), 32'(mode));
        chk("drive_oe", 32'h0, 32'(fan_drive_oe));
        lv(8'h96, 8'h32, 8'h50);
        chk("drive", 32'h1, 32'(fan_drive));
        cyc(START_CYC - 700);
        chk("mode", 32'(tfp_pkg::ST_START), 32'(mode));
        wait_mode(tfp_pkg::ST_RUN, 900);
        $display("test powerup done");
    endtask
    task automatic t_duty();
        lv(8'h7f, 8'h3c, 8'h50);
        chk("sec_ctrl", 32'h0, 32'(secondary_in_control));
        duty();
        rng("duty mid", 118, 138, h);
        lv(8'h7f, 8'h96, 8'h50);
        chk("sec_ctrl", 32'h1, 32'(secondary_in_control));
        duty();
        rng("duty sec", 175, 197, h);
        lv(8'hb9, 8'h3c, 8'h50);
        duty();
        rng("duty full", 256, 256, h);
        lv(8'hd2, 8'h3c, 8'h50);
        chk("fault_n", 32'h0, 32'(overheat_fault_n));
        chk("fault_oe", 32'h1, 32'(overheat_fault_oe));
        duty();
        rng("duty hot", 256, 256, h);
        lv(8'h7f, 8'h3c, 8'h50);
        chk("fault_n", 32'h1, 32'(overheat_fault_n));
        duty();
        rng("duty back", 118, 138, h);
        lv(8'h46, 8'h3c, 8'h28);
        duty();
        rng("duty low", 0, 0, h);
        $display("test duty done");
    endtask
    task automatic t_sleep();
        lv(8'h3c, 8'h64, 8'h50);
        chk("mode", 32'(tfp_pkg::ST_RUN), 32'(mode));
        lv(8'h3c, 8'h46, 8'h50);
        chk("mode", 32'(tfp_pkg::ST_SLEEP), 32'(mode));
        chk("drive_oe", 32'h0, 32'(fan_drive_oe));
        chk("fault_n", 32'h1, 32'(overheat_fault_n));
        lv(8'h3c, 8'h64, 8'h50);
        chk("mode", 32'(tfp_pkg::ST_SLEEP), 32'(mode));
        lv(8'h3c, 8'h78, 8'h50);
        wait_mode(tfp_pkg::ST_RUN, START_CYC + 600);
        lv(8'h28, 8'h28, 8'h00);
        chk("mode", 32'(tfp_pkg::ST_RUN), 32'(mode));
        $display("test sleep done");
    endtask
    task automatic t_shut();
        lv(8'h14, 8'hc8, 8'h00);
        chk("mode", 32'(tfp_pkg::ST_OFF), 32'(mode));
        chk("drive_oe", 32'h0, 32'(fan_drive_oe));
        chk("fault_n", 32'h1, 32'(overheat_fault_n));
        lv(8'h14, 8'h3c, 8'h50);
        lv(8'h64, 8'h3c, 8'h50);
        chk("mode", 32'(tfp_pkg::ST_SLEEP), 32'(mode));
        lv(8'h96, 8'h3c, 8'h50);
        chk("mode", 32'(tfp_pkg::ST_START), 32'(mode));
        wait_mode(tfp_pkg::ST_RUN, START_CYC + 600);
        $display("test shutdown done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Main sequence after an 8-cycle reset
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        t_powerup();
        t_duty();
        t_sleep();
        t_shut();
        summarize();
    end
    // Watchdog well past the three startup intervals
    initial begin
        repeat (90000) @(posedge core_clk);
        mismatches++;
        summarize();
    end
endmodule
bind tfp_fan_seq tfp_fan_seq_props #(.TB_PERIOD_CYC(TB_PERIOD_CYC))
    tfp_fan_seq_props_i (.core_clk(core_clk), .rstn(rstn), .levels(levels),
    .fan_drive(fan_drive), .fan_drive_oe(fan_drive_oe),
    .overheat_fault_n(overheat_fault_n),
    .overheat_fault_oe(overheat_fault_oe), .mode(mode),
    .secondary_in_control(secondary_in_control));
`default_nettype wire
